// >>> core/rsr_device.sv
// rsr_device: serial slave end of the rate sensor, clocked by the link clock.
// assumes the master keeps cs_n high between frames and sclk idles high.
//
// Contract
// - pulse sample_done_line after every sample
// - sample autonomously from reset, no command
// - mode 3, 16-bit frames, msb first
// - master keeps sclk at most 2.5 MHz
// - read reply comes in next frame
// - full duplex pipelined reads
// - shift data only after rw zero request
// - data out released while cs high
// - data out changes on falling edge
// - data in captured on rising edge
// - read request: address in upper byte
// - temperature 0x02, rate low 0x04, high 0x06
// - rate upper: two's complement, 6300 per 256
// - rate lower: msb-justified extra bits
// - aux lines gpio, fourth also sync clock
// - write frame: rw one, address, byte
// - temperature: two's complement fixed scale
// - master stalls between frames, cs high
`timescale 1ns/1ps
`default_nettype none
module rsr_device
	import rsr_pkg::*;
(
	// link clock domain, clocked by sclk
	input wire logic rst_n_i,
	rsr_link_if.device link,
	// sensor samples from the core
	input wire logic [15:0] rate_sample_i,
	input wire logic [15:0] rate_ext_i,
	input wire logic [15:0] temp_sample_i,
	// auxiliary lines
	input wire logic [2:0] aux_in_i,
	output logic [2:0] aux_out_o,
	output logic [2:0] aux_oe_o,
	input wire logic aux_io_or_sync_clock_in_i,
	output logic aux_io_or_sync_clock_in_o,
	output logic aux_io_or_sync_clock_in_oe_o,
	output logic [DEC_W-1:0] decimation_setting_o
);
	localparam logic [ADDR_W-1:0] ADDR_GPIO = 7'h1A;
	logic [CNT_W-1:0] bit_cnt_r;
	logic [14:0] rx_r;
	logic [15:0] tx_r;
	logic [15:0] rate_hi_r, rate_lo_r, temp_r;
	logic [DEC_W-1:0] decim_r;
	logic [7:0] gpio_ctrl_r;
	logic [7:0] gpio_out_r;
	logic [SAMPLE_W-1:0] smp_cnt_r;
	logic pulse_r;
	logic ext_sync_r;
	logic ext_prev_r;
	logic [15:0] frame_w;
	logic last_bit_w;
	logic ext_sync_edge_w;
	logic sample_tick_w;
	logic [15:0] lo_mask_w;
	logic [15:0] reply_w;
	wire sclk = link.sclk;

	assign frame_w = {rx_r, link.mosi};
	assign last_bit_w = (bit_cnt_r == CNT_W'(FRAME_BITS - 1));

	function automatic logic [15:0] rd_sel(input logic [ADDR_W-1:0] a,
		input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] t);
		unique case (a)
			ADDR_TEMP: rd_sel = t;
			ADDR_RATE_LO: rd_sel = lo;
			ADDR_RATE_HI: rd_sel = hi;
			default: rd_sel = ZERO_WORD;
		endcase
	endfunction : rd_sel

	assign lo_mask_w = ~(16'hFFFF >> decim_r);
	assign reply_w = rd_sel(frame_w[ADDR_MSB:ADDR_LSB], rate_hi_r,
		rate_lo_r, temp_r);

	always_ff @(posedge sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			bit_cnt_r <= '0;
			rx_r <= '0;
		end else begin
			bit_cnt_r <= bit_cnt_r + CNT_W'(1);
			rx_r <= frame_w[14:0];
		end
	end

	always_ff @(posedge sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_r <= ZERO_WORD;
		end else if (!link.cs_n && last_bit_w) begin
			tx_r <= frame_w[RW_BIT] ? ZERO_WORD : reply_w;
		end else if (!link.cs_n) begin
			tx_r <= {tx_r[14:0], 1'b0};
		end
	end

	logic miso_r;
	always_ff @(negedge sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			miso_r <= 1'b0;
		end else begin
			miso_r <= tx_r[15];
		end
	end
	// first bit is tx_r[15] directly, later bits follow each falling edge
	logic first_r;
	always_ff @(negedge sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end
	assign link.miso_o = first_r ? tx_r[15] : miso_r;
	assign link.miso_oe = ~link.cs_n;

	// byte writes: decimation and aux control
	always_ff @(posedge sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			decim_r <= '0;
			gpio_ctrl_r <= 8'h00;
			gpio_out_r <= 8'h00;
		end else if (!link.cs_n && last_bit_w && frame_w[RW_BIT]) begin
			if (frame_w[ADDR_MSB:ADDR_LSB] == ADDR_DECIM) begin
				decim_r <= frame_w[DEC_W-1:0];
			end
			if (frame_w[ADDR_MSB:ADDR_LSB] == ADDR_GPIO) begin
				gpio_ctrl_r <= frame_w[DATA_MSB:0];
			end
			if (frame_w[ADDR_MSB:ADDR_LSB] == (ADDR_GPIO + 7'h01)) begin
				gpio_out_r <= frame_w[DATA_MSB:0];
			end
		end
	end
	assign decimation_setting_o = decim_r;

	// fourth line as sync clock when ctrl bit 7 set
	logic sync_meta_w;
	rsr_sync2 u_sync (
		.clk_i(sclk),
		.rst_n_i(rst_n_i),
		.d_i(aux_io_or_sync_clock_in_i),
		.q_o(sync_meta_w)
	);
	always_ff @(posedge sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= sync_meta_w;
		end
	end
	assign ext_sync_edge_w = gpio_ctrl_r[7] && sync_meta_w && !ext_prev_r;
	assign ext_sync_r = gpio_ctrl_r[7];

	assign sample_tick_w = ext_sync_r ? ext_sync_edge_w
		: (smp_cnt_r == SAMPLE_W'(SAMPLE_CYC - 1));
	always_ff @(posedge sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			smp_cnt_r <= '0;
			pulse_r <= 1'b0;
			rate_hi_r <= ZERO_WORD;
			rate_lo_r <= ZERO_WORD;
			temp_r <= ZERO_WORD;
		end else begin
			smp_cnt_r <= sample_tick_w ? '0 : smp_cnt_r + SAMPLE_W'(1);
			pulse_r <= sample_tick_w;
			if (sample_tick_w) begin
				rate_hi_r <= rate_sample_i;
				rate_lo_r <= rate_ext_i & lo_mask_w;
				temp_r <= temp_sample_i;
			end
		end
	end
	assign link.sample_done_line = pulse_r;

	// aux b, c and fourth line as plain gpio
	assign aux_oe_o = gpio_ctrl_r[3:1];
	assign aux_out_o = gpio_out_r[3:1] | (3'b000 & aux_in_i);
	assign aux_io_or_sync_clock_in_oe_o = gpio_ctrl_r[4] & ~gpio_ctrl_r[7];
	assign aux_io_or_sync_clock_in_o = gpio_out_r[4];
endmodule : rsr_device
`default_nettype wire

// >>> pkg/rsr_pkg.sv
// rsr_pkg: constants shared by the rate sensor serial port ends.
// assumes a 16-bit mode 3 serial frame, msb first.
package rsr_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 4;
	localparam int ADDR_W = 7;
	localparam int DEC_W = 5;
	// register addresses (lower byte address)
	localparam logic [ADDR_W-1:0] ADDR_TEMP = 7'h02;
	localparam logic [ADDR_W-1:0] ADDR_RATE_LO = 7'h04;
	localparam logic [ADDR_W-1:0] ADDR_RATE_HI = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_DECIM = 7'h22;
	// frame field positions
	localparam int RW_BIT = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	// read request patterns
	localparam logic [15:0] REQ_RATE_HI = 16'h0600;
	localparam logic [15:0] REQ_RATE_LO = 16'h0400;
	localparam logic [15:0] REQ_TEMP = 16'h0200;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	// rate scale: counts per 256 deg/s
	localparam int RATE_COUNTS_PER_256DPS = 6300;
	// stall between frames, in us, and master clock divider
	localparam int STALL_US = 15;
	localparam int SYS_CLK_MHZ = 40;
	localparam int STALL_CYC = STALL_US * SYS_CLK_MHZ;
	localparam int SCLK_MAX_KHZ = 2500;
	localparam int SCLK_HALF_CYC = (SYS_CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1)
		/ (2 * SCLK_MAX_KHZ);
	localparam int STALL_W = 10;
	localparam int HALF_W = 4;
	// device sample period in link clocks
	localparam int SAMPLE_CYC = 64;
	localparam int SAMPLE_W = 7;
endpackage : rsr_pkg

// >>> pkg/rsr_link_if.sv
// rsr_link_if: serial link between master and rate sensor.
// the interface resolves the shared data-out wire, high when released.
`timescale 1ns/1ps
`default_nettype none
interface rsr_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic sample_done_line;
	logic miso;
	// the wire level seen by the master; pulled high when released
	assign miso = miso_oe ? miso_o : 1'b1;
	modport master (output sclk, output cs_n, output mosi, input miso,
		input sample_done_line);
	modport device (input sclk, input cs_n, input mosi, output miso_o,
		output miso_oe, output sample_done_line);
endinterface : rsr_link_if
`default_nettype wire

// >>> core/rsr_sync2.sv
// rsr_sync2: two-flop level synchroniser.
// assumes the input is a level from another domain.
`timescale 1ns/1ps
`default_nettype none
module rsr_sync2 (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// level
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : rsr_sync2
`default_nettype wire

// >>> core/rsr_master.sv
// rsr_master: processor-side end; issues 16-bit mode 3 frames.
// assumes registers reached over a plain strobe port on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module rsr_master
	import rsr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// link
	rsr_link_if.master link
);
	// 0x0: write starts a frame with this word; 0x4: last received word
	// 0x8: status bit0 busy, bit1 sample seen (write 1 clears)
	localparam logic [3:0] REG_TX = 4'h0;
	localparam logic [3:0] REG_RX = 4'h4;
	localparam logic [3:0] REG_ST = 4'h8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, ST_XFER = 3'b010, ST_STALL = 3'b100
	} rsr_mst_t;
	rsr_mst_t st_r;
	logic [15:0] sh_r, rx_r, rdata_r;
	logic [HALF_W-1:0] div_r;
	logic [CNT_W:0] edge_cnt_r;
	logic [STALL_W-1:0] stall_r;
	logic sclk_r, cs_n_r, seen_r, pend_r;
	logic miso_s, done_s, done_d_r;
	logic half_w, start_w;
	rsr_sync2 u_miso (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
		.d_i(link.miso), .q_o(miso_s));
	rsr_sync2 u_done (.clk_i(clk_sys_i), .rst_n_i(rst_n_i),
		.d_i(link.sample_done_line), .q_o(done_s));
	assign half_w = (div_r == HALF_W'(SCLK_HALF_CYC - 1));
	assign start_w = wr_i && (addr_i == REG_TX);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= ST_IDLE;
			sh_r <= ZERO_WORD;
			rx_r <= ZERO_WORD;
			div_r <= '0;
			edge_cnt_r <= '0;
			stall_r <= '0;
			sclk_r <= 1'b1;
			cs_n_r <= 1'b1;
			pend_r <= 1'b0;
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					if (start_w || pend_r) begin
						if (start_w) begin
							sh_r <= wdata_i;
						end
						pend_r <= 1'b0;
						cs_n_r <= 1'b0;
						div_r <= '0;
						edge_cnt_r <= '0;
						st_r <= ST_XFER;
					end
				end
				ST_XFER: begin
					div_r <= half_w ? '0 : div_r + HALF_W'(1);
					if (half_w) begin
						edge_cnt_r <= edge_cnt_r + (CNT_W+1)'(1);
						sclk_r <= ~sclk_r;
						// sample on rise, change on fall
						// first fall keeps bit 15, already out at cs low
						if (!sclk_r) begin
							rx_r <= {rx_r[14:0], miso_s};
						end else if (edge_cnt_r != '0) begin
							sh_r <= {sh_r[14:0], 1'b0};
						end
						// cs rises a cycle after the last rise, so the
						// device never sees both move in one step
						if (edge_cnt_r == (CNT_W+1)'(2 * FRAME_BITS - 1)) begin
							stall_r <= '0;
							st_r <= ST_STALL;
						end
					end
				end
				ST_STALL: begin
					cs_n_r <= 1'b1;
					if (start_w) begin
						sh_r <= wdata_i;
						pend_r <= 1'b1;
					end
					stall_r <= stall_r + STALL_W'(1);
					if (stall_r == STALL_W'(STALL_CYC - 1)) begin
						st_r <= ST_IDLE;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_d_r <= 1'b0;
			seen_r <= 1'b0;
			rdata_r <= ZERO_WORD;
		end else begin
			done_d_r <= done_s;
			if (done_s && !done_d_r) begin
				seen_r <= 1'b1;
			end else if (wr_i && addr_i == REG_ST && wdata_i[1]) begin
				seen_r <= 1'b0;
			end
			if (rd_i) begin
				rdata_r <= (addr_i == REG_RX) ? rx_r
					: (addr_i == REG_ST) ? {14'h0000, seen_r,
					st_r != ST_IDLE || pend_r} : ZERO_WORD;
			end
		end
	end
	assign rdata_o = rdata_r;
	assign link.sclk = sclk_r;
	assign link.cs_n = cs_n_r;
	assign link.mosi = sh_r[15];
endmodule : rsr_master
`default_nettype wire

// >>> sim/rsr_link_sva.sv
// rsr_link_sva: timing checks on the serial link between the two ends.
// assumes it is instantiated in the bench beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module rsr_link_sva
	import rsr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic sample_done_line,
	input wire logic miso
);
	logic [4:0] rise_cnt_r;
	logic [9:0] hi_cnt_r;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// saturating idle count, so a long idle never wraps
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_cnt_r <= 5'h00;
			hi_cnt_r <= 10'h3FF;
		end else begin
			rise_cnt_r <= cs_n ? 5'h00 : rise_cnt_r + 5'($rose(sclk));
			hi_cnt_r <= !cs_n ? 10'h000 :
				(&hi_cnt_r ? hi_cnt_r : hi_cnt_r + 10'h001);
		end
	end
	sequence half_s;
		$stable(sclk) [*7] ##1 $rose(sclk);
	endsequence
	sequence inframe_s;
		!cs_n && $past(!cs_n) && rise_cnt_r < 5'h0F;
	endsequence
	half_period_a: assert property ($fell(sclk) |=> half_s)
		else $error("sclk half period wrong");
	idle_high_a: assert property (cs_n |-> sclk)
		else $error("sclk not high while idle");
	frame_len_a: assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
		else $error("frame not 16 rising edges");
	stall_gap_a: assert property ($fell(cs_n) |-> hi_cnt_r >= 10'(STALL_CYC))
		else $error("stall between frames too short");
	release_a: assert property (cs_n && $past(cs_n) |-> !miso_oe && miso)
		else $error("data out driven while deselected");
	miso_edge_a: assert property (inframe_s ##0 $changed(miso_o) |-> $fell(sclk))
		else $error("data out changed off falling edge");
	mosi_edge_a: assert property (inframe_s ##0 $changed(mosi) |-> $fell(sclk))
		else $error("data in changed near rising edge");
	done_pulse_a: assert property (@(posedge sclk) disable iff (!rst_n_i)
		$rose(sample_done_line) |=> !sample_done_line)
		else $error("sample pulse longer than one cycle");
endmodule : rsr_link_sva
`default_nettype wire

// >>> sim/tb_rate_sensor_spi_readout.sv
// tb_rate_sensor_spi_readout: both ends joined, driven over the master port.
// assumes the device latches its sample inputs on its own sample tick.
`timescale 1ns/1ps
`default_nettype none
module tb_rate_sensor_spi_readout;
	import rsr_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] rdata_o;
	logic [15:0] v;
	logic [DEC_W-1:0] dec;
	logic sync_in = 1'b0;
	logic [2:0] aux_out;
	logic [2:0] aux_oe;
	logic aux4_o;
	logic aux4_oe;
	int err_count = 0;
	int n_checks = 0;
	rsr_link_if link_if();
	always #12.5 clk_sys_i = ~clk_sys_i;
	rsr_master rsr_master_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .link(link_if));
	rsr_device rsr_device_inst (.rst_n_i(rst_n_i), .link(link_if),
		.rate_sample_i(16'h6021), .rate_ext_i(16'hA000),
		.temp_sample_i(16'hF165), .aux_in_i(3'h5), .aux_out_o(aux_out),
		.aux_oe_o(aux_oe), .aux_io_or_sync_clock_in_i(sync_in),
		.aux_io_or_sync_clock_in_o(aux4_o),
		.aux_io_or_sync_clock_in_oe_o(aux4_oe),
		.decimation_setting_o(dec));
	rsr_link_sva rsr_link_sva_inst (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
		.mosi(link_if.mosi), .miso_o(link_if.miso_o),
		.miso_oe(link_if.miso_oe), .miso(link_if.miso),
		.sample_done_line(link_if.sample_done_line));
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask : rd
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// one frame, then wait out the stall on the busy flag
	task automatic xfer(input logic [15:0] d);
		int i;
		wr(4'h0, d);
		for (i = 0; i < 2000; i++) begin
			rd(4'h8);
			if (v[0] === 1'b0) break;
		end
		if (i == 2000) begin
			err_count++;
			$display("[ERR] %0t: busy stuck", $time);
		end
	endtask : xfer
	// write frame; a following frame must carry no reply
	task automatic t_write;
		chk(16'(link_if.sclk), 16'h0001);
		chk(16'(link_if.miso), 16'h0001);
		xfer(16'hA203);
		chk(16'(dec), 16'h0003);
		xfer(ZERO_WORD);
		rd(4'h4);
		chk(v, 16'h0000);
	endtask : t_write
	// pipelined reads; warm-up frames give the sample tick its clocks
	task automatic t_reads;
		repeat (4) xfer(REQ_RATE_HI);
		rd(4'h8);
		chk(16'(v[1]), 16'h0001);
		wr(4'h8, 16'h0002);
		rd(4'h8);
		chk(16'(v[1]), 16'h0000);
		xfer(REQ_RATE_LO);
		rd(4'h4);
		chk(v, 16'h6021);
		xfer(REQ_TEMP);
		rd(4'h4);
		chk(v, 16'hA000);
		xfer(ZERO_WORD);
		rd(4'h4);
		chk(v, 16'hF165);
		wr(4'hC, 16'hFFFF);
		rd(4'h4);
		chk(v, 16'hF165);
		// data is latched by now, so a reply here would be non-zero
		xfer(16'h8600);
		xfer(ZERO_WORD);
		rd(4'h4);
		chk(v, ZERO_WORD);
	endtask : t_reads
	// gpio control, then the fourth line as sample clock
	task automatic t_aux;
		xfer(16'h9A12);
		xfer(16'h9B1E);
		chk(16'(aux_oe), 16'h0001);
		chk(16'(aux_out), 16'h0007);
		chk(16'({aux4_oe, aux4_o}), 16'h0003);
		xfer(16'h9A92);
		chk(16'(aux4_oe), 16'h0000);
		wr(4'h8, 16'h0002);
		// more than a timer period of edges, yet no sync edge
		repeat (5) xfer(ZERO_WORD);
		rd(4'h8);
		chk(16'(v[1]), 16'h0000);
		sync_in <= 1'b1;
		xfer(ZERO_WORD);
		rd(4'h8);
		chk(16'(v[1]), 16'h0001);
	endtask : t_aux
	task automatic results;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_write;
		t_reads;
		t_aux;
		results;
	end
	initial begin
		#2000000;
		err_count++;
		$display("[ERR] %0t: watchdog expired", $time);
		results;
	end
endmodule : tb_rate_sensor_spi_readout
`default_nettype wire
